// [hw/dsm_pkg.sv]
package dsm_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned PAT_W  = 10;
   localparam int unsigned MODE_W = 3;

   // Device register offsets on the drive bus
   localparam logic [15:0] OFS_CMD    = 16'h6040;
   localparam logic [15:0] OFS_STATUS = 16'h6041;
   localparam logic [15:0] OFS_QSO    = 16'h605A;
   localparam logic [15:0] OFS_REF    = 16'h2100;

   // Reset values
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam logic [15:0] QSO_RESET = 16'h0000;
   localparam logic [15:0] REF_RESET = 16'h0000;

   // Status patterns, bits 0 to 9
   localparam logic [9:0] ST_INIT       = 10'h000;
   localparam logic [9:0] ST_NOFAULT    = 10'h270;
   localparam logic [9:0] ST_NOFAULT_RD = 10'h250;
   localparam logic [9:0] ST_READY      = 10'h231;
   localparam logic [9:0] ST_WAITEN     = 10'h233;
   localparam logic [9:0] ST_RUN        = 10'h237;
   localparam logic [9:0] ST_QSTOP      = 10'h217;
   localparam logic [9:0] ST_STOPFLT    = 10'h21F;
   localparam logic [9:0] ST_FAULT      = 10'h238;
   localparam logic [5:0] ST_UPPER      = 6'h00;

   // Control word patterns and fields
   localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
   localparam logic [15:0] CW_SWITCHON = 16'h0007;
   localparam logic [15:0] CW_ENABLE   = 16'h000F;
   localparam logic [15:0] CW_DISABLE  = 16'h0000;
   localparam logic [15:0] CW_QSTOP    = 16'h0002;
   localparam logic [15:0] CW_RESET    = 16'h0080;
   localparam logic [15:0] CW_MODE_MSK = 16'h0070;
   localparam int unsigned CW_RST_BIT  = 7;
   localparam int unsigned CW_MODE_LSB = 4;

   // Quick-stop option ranges
   localparam logic [15:0] QSO_AUTO_MAX = 16'h0003;
   localparam logic [15:0] QSO_HOLD_MIN = 16'h0005;
   localparam logic [15:0] QSO_HOLD_MAX = 16'h0007;

   // Host user-side register map
   localparam int unsigned HADDR_W     = 4;
   localparam logic [3:0]  HREG_CMD    = 4'h0;
   localparam logic [3:0]  HREG_QSO    = 4'h1;
   localparam logic [3:0]  HREG_REF    = 4'h2;
   localparam logic [3:0]  HREG_STATUS = 4'h3;
   localparam logic [3:0]  HREG_FLAGS  = 4'h4;
   localparam int unsigned FLAG_REFUSED = 0;
   localparam int unsigned FLAG_SEQ     = 1;

   typedef enum logic [2:0] {
      S_INIT    = 3'b000,
      S_NOFAULT = 3'b001,
      S_READY   = 3'b010,
      S_WAITEN  = 3'b011,
      S_RUN     = 3'b100,
      S_QSTOP   = 3'b101,
      S_STOPFLT = 3'b110,
      S_FAULT   = 3'b111
   } dsm_state_e;

   typedef enum logic [2:0] {
      C_NONE     = 3'b000,
      C_SHUTDOWN = 3'b001,
      C_SWITCHON = 3'b010,
      C_ENABLE   = 3'b011,
      C_DISABLE  = 3'b100,
      C_QSTOP    = 3'b101,
      C_RESET    = 3'b110
   } dsm_cmd_e;
endpackage

// [hw/dsm_if.sv]
interface dsm_if;
   logic        wr;
   logic        rd;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        err;

   // Drive end is the slave of the process-data bus
   modport drv (
      input  wr,
      input  rd,
      input  addr,
      input  wdata,
      output rdata,
      output err
   );

   modport hst (
      output wr,
      output rd,
      output addr,
      output wdata,
      input  rdata,
      input  err
   );
endinterface

// [hw/dsm_cmd_decode.sv]
module dsm_cmd_decode (
   input  wire logic [15:0]       new_word,
   input  wire logic [15:0]       old_word,
   output dsm_pkg::dsm_cmd_e      cmd
);
   logic [15:0] body;

   // Mode bits are masked; the rest is matched as one pattern
   always_comb begin
      body = new_word & ~dsm_pkg::CW_MODE_MSK;
      cmd  = dsm_pkg::C_NONE;
      if (new_word[dsm_pkg::CW_RST_BIT]) begin
         if (!old_word[dsm_pkg::CW_RST_BIT]) begin
            cmd = dsm_pkg::C_RESET;
         end
      end else begin
         case (body)
            dsm_pkg::CW_SHUTDOWN: cmd = dsm_pkg::C_SHUTDOWN;
            dsm_pkg::CW_SWITCHON: cmd = dsm_pkg::C_SWITCHON;
            dsm_pkg::CW_ENABLE:   cmd = dsm_pkg::C_ENABLE;
            dsm_pkg::CW_DISABLE:  cmd = dsm_pkg::C_DISABLE;
            dsm_pkg::CW_QSTOP:    cmd = dsm_pkg::C_QSTOP;
            default:              cmd = dsm_pkg::C_NONE;
         endcase
      end
   end
endmodule // dsm_cmd_decode

// [hw/dsm_drive.sv]
module dsm_drive #(
   parameter int unsigned WORD_W = dsm_pkg::WORD_W,
   parameter int unsigned MODE_W = dsm_pkg::MODE_W
) (
   input  wire logic              CLK_SYS,
   input  wire logic              RST,
   dsm_if.drv                     BUS,
   input  wire logic              INIT_DONE,      // Self-check finished, same clock
   input  wire logic              INIT_ERR,       // Self-check failed
   input  wire logic              FAULT_IN,       // Fault present, level
   input  wire logic              STOP_DONE,      // Deceleration finished
   output logic                   MOTOR_ENERGIZE,
   output logic                   MOTOR_MOVE,
   output logic                   QSTOP_DECEL,
   output logic                   FAULT_STOP,
   output logic                   DRIVE_FUNC_EN,
   output logic [MODE_W-1:0]      MODE_BITS,
   output logic [WORD_W-1:0]      REFERENCE
);
   // Field widths are fixed by the control word layout
   if (WORD_W != 16 || MODE_W != 3) begin : g_bad_width
      $error("dsm_drive needs WORD_W 16 and MODE_W 3");
   end

   typedef struct packed {
      dsm_pkg::dsm_state_e state;
      logic [9:0]          pat;
      logic [15:0]         cw;
      logic [15:0]         qso;
      logic [15:0]         ref_v;
      logic                stopped;
      logic [15:0]         rdata;
      logic                err;
      logic                energize;
      logic                move;
      logic                decel;
      logic                fstop;
      logic                func_en;
      logic [2:0]          mode;
   } dsm_drv_s;

   dsm_drv_s            s_q;
   dsm_drv_s            s_d;
   dsm_pkg::dsm_cmd_e   dec_cmd;
   dsm_pkg::dsm_cmd_e   cmd;
   logic                cmd_wr;
   logic                qso_auto;
   logic                qso_hold;

   // Decoder sees the incoming word against the stored one for bit 7 edges
   dsm_cmd_decode u_dec (
      .new_word (BUS.wdata),
      .old_word (s_q.cw),
      .cmd      (dec_cmd)
   );

   // A command counts only when written outside initialization
   assign cmd_wr   = BUS.wr && (BUS.addr == dsm_pkg::OFS_CMD) && (s_q.state != dsm_pkg::S_INIT);
   assign cmd      = cmd_wr ? dec_cmd : dsm_pkg::C_NONE;
   assign qso_auto = (s_q.qso <= dsm_pkg::QSO_AUTO_MAX);
   assign qso_hold = (s_q.qso >= dsm_pkg::QSO_HOLD_MIN) && (s_q.qso <= dsm_pkg::QSO_HOLD_MAX);

   // Next state: bus slave, sequencer, then registered outputs
   always_comb begin
      s_d       = s_q;
      s_d.err   = 1'b0;
      s_d.rdata = '0;

      // Writes refused during initialization; unmapped writes flagged too
      if (BUS.wr) begin
         if (s_q.state == dsm_pkg::S_INIT) begin
            s_d.err = 1'b1;
         end else begin
            case (BUS.addr)
               dsm_pkg::OFS_CMD: s_d.cw    = BUS.wdata;
               dsm_pkg::OFS_QSO: s_d.qso   = BUS.wdata;
               dsm_pkg::OFS_REF: s_d.ref_v = BUS.wdata;
               default:          s_d.err   = 1'b1;
            endcase
         end
      end

      // Read data stands the cycle after the strobe; unmapped reads zero
      if (BUS.rd) begin
         case (BUS.addr)
            dsm_pkg::OFS_CMD:    s_d.rdata = s_q.cw;
            dsm_pkg::OFS_STATUS: s_d.rdata = {dsm_pkg::ST_UPPER, s_q.pat};
            dsm_pkg::OFS_QSO:    s_d.rdata = s_q.qso;
            dsm_pkg::OFS_REF:    s_d.rdata = s_q.ref_v;
            default:             s_d.rdata = '0;
         endcase
      end

      // Sequencer; any pattern not listed for a state is dropped
      case (s_q.state)
         dsm_pkg::S_INIT: begin
            if (INIT_ERR) begin
               s_d.state = dsm_pkg::S_STOPFLT;
               s_d.pat   = dsm_pkg::ST_STOPFLT;
            end else if (INIT_DONE) begin
               s_d.state = dsm_pkg::S_NOFAULT;
               s_d.pat   = dsm_pkg::ST_NOFAULT;
            end
         end
         dsm_pkg::S_NOFAULT: begin
            if (cmd == dsm_pkg::C_SHUTDOWN) begin
               s_d.state = dsm_pkg::S_READY;
               s_d.pat   = dsm_pkg::ST_READY;
            end
         end
         dsm_pkg::S_READY: begin
            if (cmd == dsm_pkg::C_SWITCHON) begin
               s_d.state = dsm_pkg::S_WAITEN;
               s_d.pat   = dsm_pkg::ST_WAITEN;
            end else if (cmd == dsm_pkg::C_DISABLE) begin
               s_d.state = dsm_pkg::S_NOFAULT;
               s_d.pat   = dsm_pkg::ST_NOFAULT_RD;
            end
         end
         dsm_pkg::S_WAITEN: begin
            if (cmd == dsm_pkg::C_ENABLE) begin
               s_d.state = dsm_pkg::S_RUN;
               s_d.pat   = dsm_pkg::ST_RUN;
            end else if (cmd == dsm_pkg::C_SHUTDOWN) begin
               s_d.state = dsm_pkg::S_READY;
               s_d.pat   = dsm_pkg::ST_READY;
            end else if (cmd == dsm_pkg::C_DISABLE) begin
               s_d.state = dsm_pkg::S_NOFAULT;
               s_d.pat   = dsm_pkg::ST_NOFAULT;
            end
         end
         dsm_pkg::S_RUN: begin
            if (cmd == dsm_pkg::C_SWITCHON) begin
               s_d.state = dsm_pkg::S_WAITEN;
               s_d.pat   = dsm_pkg::ST_WAITEN;
            end else if (cmd == dsm_pkg::C_SHUTDOWN) begin
               s_d.state = dsm_pkg::S_READY;
               s_d.pat   = dsm_pkg::ST_READY;
            end else if (cmd == dsm_pkg::C_DISABLE) begin
               s_d.state = dsm_pkg::S_NOFAULT;
               s_d.pat   = dsm_pkg::ST_NOFAULT;
            end else if (cmd == dsm_pkg::C_QSTOP) begin
               s_d.state   = dsm_pkg::S_QSTOP;
               s_d.pat     = dsm_pkg::ST_QSTOP;
               s_d.stopped = 1'b0;
            end
         end
         dsm_pkg::S_QSTOP: begin
            // Resume is only honoured once the axis is at rest
            if (!s_q.stopped && STOP_DONE) begin
               if (qso_auto) begin
                  s_d.state = dsm_pkg::S_NOFAULT;
                  s_d.pat   = dsm_pkg::ST_NOFAULT;
               end else begin
                  s_d.stopped = 1'b1;
               end
            end else if (s_q.stopped && qso_hold && cmd == dsm_pkg::C_ENABLE) begin
               s_d.state = dsm_pkg::S_RUN;
               s_d.pat   = dsm_pkg::ST_RUN;
            end
         end
         dsm_pkg::S_STOPFLT: begin
            if (STOP_DONE) begin
               s_d.state = dsm_pkg::S_FAULT;
               s_d.pat   = dsm_pkg::ST_FAULT;
            end
         end
         dsm_pkg::S_FAULT: begin
            if (cmd == dsm_pkg::C_RESET) begin
               s_d.state = dsm_pkg::S_NOFAULT;
               s_d.pat   = dsm_pkg::ST_NOFAULT;
            end
         end
         default: begin
            s_d.state = dsm_pkg::S_INIT;
            s_d.pat   = dsm_pkg::ST_INIT;
         end
      endcase

      // Fault wins over any command in the same cycle, except a fault reset in the fault state
      if (FAULT_IN && s_q.state != dsm_pkg::S_FAULT && s_q.state != dsm_pkg::S_STOPFLT) begin
         s_d.state = dsm_pkg::S_STOPFLT;
         s_d.pat   = dsm_pkg::ST_STOPFLT;
      end

      // Outputs follow the next state so they change with the status word
      s_d.energize = (s_d.state == dsm_pkg::S_RUN);
      s_d.move     = s_d.energize && (s_d.ref_v != '0);
      s_d.decel    = (s_d.state == dsm_pkg::S_QSTOP) && !s_d.stopped;
      s_d.fstop    = (s_d.state == dsm_pkg::S_STOPFLT);
      s_d.func_en  = (s_d.state == dsm_pkg::S_RUN) || (s_d.state == dsm_pkg::S_QSTOP) ||
                     (s_d.state == dsm_pkg::S_STOPFLT);
      s_d.mode     = s_d.energize ? s_d.cw[dsm_pkg::CW_MODE_LSB +: 3] : 3'h0;
   end

   // Reset gives initialization with status 0000h and all outputs low
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s_q       <= '0;
         s_q.state <= dsm_pkg::S_INIT;
         s_q.pat   <= dsm_pkg::ST_INIT;
         s_q.cw    <= dsm_pkg::CMD_RESET;
         s_q.qso   <= dsm_pkg::QSO_RESET;
         s_q.ref_v <= dsm_pkg::REF_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign BUS.rdata      = s_q.rdata;
   assign BUS.err        = s_q.err;
   assign MOTOR_ENERGIZE = s_q.energize;
   assign MOTOR_MOVE     = s_q.move;
   assign QSTOP_DECEL    = s_q.decel;
   assign FAULT_STOP     = s_q.fstop;
   assign DRIVE_FUNC_EN  = s_q.func_en;
   assign MODE_BITS      = s_q.mode;
   assign REFERENCE      = s_q.ref_v;
endmodule // dsm_drive

// [hw/dsm_host.sv]
module dsm_host (
   input  wire logic              CLK_SYS,
   input  wire logic              RST,
   input  wire logic [3:0]        ADDR,
   input  wire logic [15:0]       WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic [15:0]            RDATA,
   dsm_if.hst                     BUS
);
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        rd_pend;   // A poll answer arrives this cycle
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] status;
      logic [15:0] last_cw;
      logic [1:0]  flags;
      logic [15:0] rdata;
   } dsm_hst_s;

   dsm_hst_s s_q;
   dsm_hst_s s_d;

   // True when the word is a valid step from the last polled status
   function automatic logic cmd_legal(input logic [9:0] pat, input logic [15:0] cw);
      logic ok;
      ok = 1'b0;
      case (cw & ~dsm_pkg::CW_MODE_MSK)
         dsm_pkg::CW_SHUTDOWN: ok = (pat == dsm_pkg::ST_NOFAULT) || (pat == dsm_pkg::ST_NOFAULT_RD) ||
                                    (pat == dsm_pkg::ST_WAITEN) || (pat == dsm_pkg::ST_RUN);
         dsm_pkg::CW_SWITCHON: ok = (pat == dsm_pkg::ST_READY) || (pat == dsm_pkg::ST_RUN);
         dsm_pkg::CW_ENABLE:   ok = (pat == dsm_pkg::ST_WAITEN) || (pat == dsm_pkg::ST_QSTOP);
         dsm_pkg::CW_DISABLE:  ok = (pat == dsm_pkg::ST_READY) || (pat == dsm_pkg::ST_WAITEN) ||
                                    (pat == dsm_pkg::ST_RUN);
         dsm_pkg::CW_QSTOP:    ok = (pat == dsm_pkg::ST_RUN);
         dsm_pkg::CW_RESET:    ok = (pat == dsm_pkg::ST_FAULT);
         default:              ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Forward writes next cycle; poll the status word whenever the bus is free
   always_comb begin
      s_d       = s_q;
      s_d.wr    = 1'b0;
      s_d.rd    = 1'b0;
      s_d.rdata = '0;
      // Drive answers a poll one cycle late; a write cycle leaves a zero answer behind
      s_d.rd_pend = s_q.rd;
      if (s_q.rd_pend) begin
         s_d.status = BUS.rdata;
      end
      // Clear first so that a set in the same cycle wins
      if (WR && ADDR == dsm_pkg::HREG_FLAGS) begin
         s_d.flags = s_q.flags & ~WDATA[1:0];
      end
      if (BUS.err) begin
         s_d.flags[dsm_pkg::FLAG_REFUSED] = 1'b1;
      end
      if (WR) begin
         case (ADDR)
            dsm_pkg::HREG_CMD: begin
               s_d.wr      = 1'b1;
               s_d.addr    = dsm_pkg::OFS_CMD;
               s_d.wdata   = WDATA;
               s_d.last_cw = WDATA;
               if (!cmd_legal(s_q.status[9:0], WDATA)) begin
                  s_d.flags[dsm_pkg::FLAG_SEQ] = 1'b1;
               end
            end
            dsm_pkg::HREG_QSO: begin
               s_d.wr    = 1'b1;
               s_d.addr  = dsm_pkg::OFS_QSO;
               s_d.wdata = WDATA;
            end
            dsm_pkg::HREG_REF: begin
               s_d.wr    = 1'b1;
               s_d.addr  = dsm_pkg::OFS_REF;
               s_d.wdata = WDATA;
            end
            default: begin
               s_d.wr = 1'b0;
            end
         endcase
      end
      if (!s_d.wr) begin
         s_d.rd   = 1'b1;
         s_d.addr = dsm_pkg::OFS_STATUS;
      end
      if (RD) begin
         case (ADDR)
            dsm_pkg::HREG_CMD:    s_d.rdata = s_q.last_cw;
            dsm_pkg::HREG_STATUS: s_d.rdata = s_q.status;
            dsm_pkg::HREG_FLAGS:  s_d.rdata = {14'h0000, s_q.flags};
            default:              s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign BUS.wr    = s_q.wr;
   assign BUS.rd    = s_q.rd;
   assign BUS.addr  = s_q.addr;
   assign BUS.wdata = s_q.wdata;
   assign RDATA     = s_q.rdata;
endmodule // dsm_host

// [tb/dsm_props.sv]
module dsm_props (
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        rd_q;
   logic [15:0] addr_q;

   // Which request the present rdata answers
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         rd_q   <= 1'b0;
         addr_q <= 16'h0000;
      end else begin
         rd_q   <= rd;
         addr_q <= addr;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   // A poll answer showing a pattern, and a command write
   sequence s_poll(logic [9:0] p);
      rd_q && addr_q == dsm_pkg::OFS_STATUS && rdata == {6'h00, p};
   endsequence
   sequence s_cmd(logic [15:0] cw);
      wr && addr == dsm_pkg::OFS_CMD && wdata == cw;
   endsequence
   // New state lands one edge after the write, so the next poll answer shows it
   property p_step(logic [9:0] a, logic [15:0] cw, logic [9:0] b);
      s_poll(a) ##0 s_cmd(cw) |-> ##2 rdata == {6'h00, b};
   endproperty

   AST_ONE_STROBE: assert property (!(wr && rd)) else $error("write and read strobes together");
   AST_REFUSE: assert property (s_poll(dsm_pkg::ST_INIT) ##0 wr |-> ##1 err)
      else $error("write during initialization not refused");
   AST_ACCEPT: assert property (rd_q && addr_q == dsm_pkg::OFS_STATUS
      && rdata[9:0] inside {10'h270, 10'h250, 10'h231, 10'h233} ##0 wr && addr == dsm_pkg::OFS_QSO |-> ##1 !err)
      else $error("parameter write refused in idle state");
   AST_SHUTDOWN: assert property (p_step(dsm_pkg::ST_NOFAULT, 16'h0006, dsm_pkg::ST_READY))
      else $error("shutdown did not reach ready");
   AST_SWITCHON: assert property (p_step(dsm_pkg::ST_READY, 16'h0007, dsm_pkg::ST_WAITEN))
      else $error("switch on did not reach wait state");
   AST_ENABLE: assert property (p_step(dsm_pkg::ST_WAITEN, 16'h000F, dsm_pkg::ST_RUN))
      else $error("enable did not reach running");
   AST_BACK: assert property (p_step(dsm_pkg::ST_RUN, 16'h0007, dsm_pkg::ST_WAITEN))
      else $error("running did not fall back to wait state");
   AST_OFF_READY: assert property (p_step(dsm_pkg::ST_READY, 16'h0000, dsm_pkg::ST_NOFAULT_RD))
      else $error("disable from ready wrong");
   AST_OFF_RUN: assert property (p_step(dsm_pkg::ST_RUN, 16'h0000, dsm_pkg::ST_NOFAULT))
      else $error("disable from running wrong");
   AST_QSTOP: assert property (p_step(dsm_pkg::ST_RUN, 16'h0002, dsm_pkg::ST_QSTOP))
      else $error("quick stop not entered");
   AST_CLEAR: assert property (p_step(dsm_pkg::ST_FAULT, 16'h0080, dsm_pkg::ST_NOFAULT))
      else $error("fault reset did not clear");
   AST_HOLD: assert property (rd_q && addr_q == dsm_pkg::OFS_STATUS
      && rdata[9:0] inside {10'h270, 10'h231, 10'h233, 10'h237}
      ##0 wr && addr == dsm_pkg::OFS_CMD && (wdata == 16'h0003 || wdata == 16'h008F)
      |-> ##2 rdata == $past(rdata, 2)) else $error("unmatched pattern changed state");
endmodule // dsm_props

// [tb/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK_SYS = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
   logic [3:0]  ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0000, RDATA, REFERENCE, cwq = 16'h0000, refv = 16'h0000, v;
   logic        INIT_DONE = 1'b0, INIT_ERR = 1'b0, FAULT_IN = 1'b0, STOP_DONE = 1'b0;
   logic        MOTOR_ENERGIZE, MOTOR_MOVE, QSTOP_DECEL, FAULT_STOP, DRIVE_FUNC_EN;
   logic [2:0]  MODE_BITS;
   logic [31:0] r = 32'h0001494C;
   logic [15:0] q[$];
   int          st = 0, opt = 0, stopped = 0, fails = 0, comparisons = 0, cycles = 0;

   dsm_if bus ();
   dsm_drive i_dsm_drive (.CLK_SYS(CLK_SYS), .RST(RST), .BUS(bus), .INIT_DONE(INIT_DONE), .INIT_ERR(INIT_ERR),
      .FAULT_IN(FAULT_IN), .STOP_DONE(STOP_DONE), .MOTOR_ENERGIZE(MOTOR_ENERGIZE), .MOTOR_MOVE(MOTOR_MOVE),
      .QSTOP_DECEL(QSTOP_DECEL), .FAULT_STOP(FAULT_STOP), .DRIVE_FUNC_EN(DRIVE_FUNC_EN), .MODE_BITS(MODE_BITS),
      .REFERENCE(REFERENCE));
   dsm_host i_dsm_host (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .BUS(bus));
   dsm_props i_dsm_props (.CLK_SYS(CLK_SYS), .RST(RST), .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
      .wdata(bus.wdata), .rdata(bus.rdata), .err(bus.err));

   // 40 MHz clock, and a cycle ceiling well above the planned run
   always #12.5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         results();
      end
   end

   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Reference state machine; mode bits 4 to 6 are masked before matching
   function int nxt(input int s, input logic [15:0] cw);
      logic [15:0] m;
      m = cw & 16'hFF8F;
      if (cw[7]) return (s == 'h238 && !cwq[7]) ? 'h270 : s;
      if (m == 16'h0006 && s inside {'h270, 'h250, 'h233, 'h237}) return 'h231;
      if (m == 16'h0007 && s inside {'h231, 'h237}) return 'h233;
      if (m == 16'h000F && (s == 'h233 || (s == 'h217 && stopped == 1 && opt >= 5))) return 'h237;
      if (m == 16'h0000 && s inside {'h233, 'h237}) return 'h270;
      if (m == 16'h0000 && s == 'h231) return 'h250;
      if (m == 16'h0002 && s == 'h237) return 'h217;
      return s;
   endfunction

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle strobes; settle time covers bus write, state edge and status poll
   task wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
   endtask

   task rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask

   task check;
      rreg(dsm_pkg::HREG_STATUS, v);
      chk("status", v, st[15:0]);
      chk("energize", MOTOR_ENERGIZE, st == 'h237);
      chk("move", MOTOR_MOVE, st == 'h237 && refv != 0);
      chk("fault_stop", FAULT_STOP, st == 'h21F);
      chk("func_en", DRIVE_FUNC_EN, st inside {'h237, 'h217, 'h21F});
      chk("mode", MODE_BITS, st == 'h237 ? cwq[6:4] : 3'h0);
      chk("decel", QSTOP_DECEL, st == 'h217 && stopped == 0);
      chk("reference", REFERENCE, refv);
   endtask

   task cmd(input logic [15:0] cw);
      wreg(dsm_pkg::HREG_CMD, cw);
      if (st != 0) begin
         st = nxt(st, cw);
         cwq = cw;
      end
      if (st != 'h217) stopped = 0;
      check();
   endtask

   // Pulse one drive event: 0 init done, 1 init error, 2 fault, 3 stop complete
   task ev(input int k);
      @(posedge CLK_SYS);
      case (k)
         0: INIT_DONE <= 1'b1;
         1: INIT_ERR <= 1'b1;
         2: FAULT_IN <= 1'b1;
         default: STOP_DONE <= 1'b1;
      endcase
      @(posedge CLK_SYS);
      {INIT_DONE, INIT_ERR, FAULT_IN, STOP_DONE} <= 4'h0;
      if (st == 0 && k < 2) st = k ? 'h21F : 'h270;
      if (k == 2 && !(st inside {'h238, 'h21F})) st = 'h21F;
      if (k == 3 && st == 'h21F) st = 'h238;
      else if (k == 3 && st == 'h217 && stopped == 0 && opt <= 3) st = 'h270;
      else if (k == 3 && st == 'h217) stopped = 1;
      repeat (6) @(posedge CLK_SYS);
      check();
   endtask

   task results;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST <= 1'b0;
      check();
      wreg(dsm_pkg::HREG_QSO, 16'h0006);
      rreg(dsm_pkg::HREG_FLAGS, v);
      chk("refused", v[0], 1'b1);
      wreg(dsm_pkg::HREG_FLAGS, 16'h0001);
      ev(0);
      wreg(dsm_pkg::HREG_REF, 16'h0123);
      refv = 16'h0123;
      q = '{16'h6, 16'h7, 16'h8F, 16'h5F, 16'h3, 16'h7, 16'hF, 16'h6, 16'h0, 16'h6, 16'h7, 16'hF, 16'h0};
      foreach (q[i]) cmd(q[i]);
      // 008Fh and 0003h fit no step from the polled state, so the host flags them
      rreg(dsm_pkg::HREG_FLAGS, v);
      chk("seq_flag", v, 16'h0002);
      wreg(dsm_pkg::HREG_FLAGS, 16'h0003);
      $display("test command sequence done");
      q = '{16'h6, 16'h7, 16'hF, 16'h2};
      foreach (q[i]) cmd(q[i]);
      rreg(dsm_pkg::HREG_FLAGS, v);
      chk("seq_flag", v, 16'h0000);
      ev(3);
      wreg(dsm_pkg::HREG_QSO, 16'h0006);
      opt = 6;
      q = '{16'h6, 16'h7, 16'hF, 16'h2, 16'hF};
      foreach (q[i]) cmd(q[i]);
      ev(3);
      cmd(16'h000F);
      $display("test quick stop done");
      ev(2);
      cmd(16'h000F);
      ev(3);
      cmd(16'h0006);
      cmd(16'h0080);
      $display("test fault done");
      for (int i = 0; i < 60; i++) begin
         r = lfsr(r);
         if (i == 0) wreg(dsm_pkg::HREG_REF, r[15:0]);
         if (i == 0) refv = r[15:0];
         q = '{16'h6, 16'h7, 16'hF, 16'h0, 16'h2, 16'h8F, 16'h3, 16'h5F};
         if (r[5:3] == 3'h7) ev(3);
         else cmd(q[r[2:0]]);
      end
      $display("test random commands done");
      @(posedge CLK_SYS);
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      st = 0;
      opt = 0;
      stopped = 0;
      cwq = 16'h0000;
      refv = 16'h0000;
      check();
      ev(1);
      $display("test init error done");
      results();
   end
endmodule // testbench
